// ---- rtl/resb_pkg.sv ----
// Constants of the regulator event and status bank.
// Assumes a 200 MHz register clock and a byte-wide register port.
package resb_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RESB_SW_EVT_ADDR  = 8'h1b;
  localparam logic [7:0] RESB_LIN_EVT_ADDR = 8'h1c;
  localparam logic [7:0] RESB_GSTAT_ADDR   = 8'h1d;
  localparam logic [7:0] RESB_SWSTAT_ADDR  = 8'h1e;

  // ----------------------------------------------------------------
  // Event register fields (same layout for both event registers)
  // ----------------------------------------------------------------
  localparam int         RESB_EVT_B_PG   = 6;
  localparam int         RESB_EVT_B_SC   = 5;
  localparam int         RESB_EVT_B_IL   = 4;
  localparam int         RESB_EVT_A_PG   = 2;
  localparam int         RESB_EVT_A_SC   = 1;
  localparam int         RESB_EVT_A_IL   = 0;
  localparam logic [7:0] RESB_EVT_MASK   = 8'h77;
  localparam logic [7:0] RESB_RESET_VAL  = 8'h00;

  // ----------------------------------------------------------------
  // Global status fields
  // ----------------------------------------------------------------
  localparam int         RESB_GS_POWER_OK = 7;
  localparam int         RESB_GS_SYNC_BAD = 4;
  localparam int         RESB_GS_TSD      = 3;
  localparam int         RESB_GS_TWARN    = 2;
  localparam int         RESB_GS_OVP      = 1;

  // ----------------------------------------------------------------
  // Switcher status fields
  // ----------------------------------------------------------------
  localparam int         RESB_SS_B_EN     = 7;
  localparam int         RESB_SS_B_INV    = 6;
  localparam int         RESB_SS_B_LIM    = 4;
  localparam int         RESB_SS_A_EN     = 3;
  localparam int         RESB_SS_A_INV    = 2;
  localparam int         RESB_SS_A_LIM    = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         RESB_CLK_MHZ     = 200;
  localparam int         RESB_SC_TIME_US  = 1000;
  localparam int         RESB_SC_CYCLES   = RESB_SC_TIME_US * RESB_CLK_MHZ;
  localparam int         RESB_NUM_REG     = 4;

endpackage : resb_pkg

// ---- rtl/resb_evt_if.sv ----
// Carrier between the bank and one sticky event register.
// Assumes one clock; set and clear are single-cycle vectors.
`timescale 1ns/1ps
interface resb_evt_if #(parameter int W = 8);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;
  modport latch (input set, input clr, output q);
  modport user  (output set, output clr, input q);
endinterface : resb_evt_if

// ---- rtl/resb_event_latch.sv ----
// Sticky event register with write-one-to-clear.
// Assumes set and clear vectors are synchronous to i_clock.
`timescale 1ns/1ps
module resb_event_latch
  import resb_pkg::*;
#(
  parameter int         W    = 8,
  parameter logic [7:0] MASK = RESB_EVT_MASK
)
(
  // Clock and reset
  input  wire logic     i_clock,
  input  wire logic     i_nrst,
  // Event carrier
  resb_evt_if.latch     evt
);

  typedef struct packed
  {
    logic [W-1:0] q;
  } resb_latch_s;

  resb_latch_s st_r;
  resb_latch_s st_nxt;

  // ----------------------------------------------------------------
  // Latch update
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt   = st_r;
    st_nxt.q = ((st_r.q & ~evt.clr) | evt.set) & MASK[W-1:0];
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign evt.q = st_r.q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  set_wins_a: assert property ((|(evt.set & evt.clr)) |=> (|evt.q))
    else $error("event lost against a clear");
  clear_only_a: assert property (evt.set == '0 |=> (evt.q & $past(evt.clr)) == '0)
    else $error("cleared bit stayed set");

endmodule : resb_event_latch

// ---- rtl/resb_short_timer.sv ----
// Qualifies a short-circuit comparator level over a long run of cycles.
// Assumes the comparator level is synchronous to i_clock.
`timescale 1ns/1ps
module resb_short_timer
#(
  parameter int LIMIT = 200000
)
(
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_nrst,
  // Comparator and result
  input  wire logic i_below,
  output logic      o_event
);

  localparam int CW = $clog2(LIMIT + 1);

  typedef struct packed
  {
    logic [CW-1:0] cnt;
    logic          fired;
  } resb_timer_s;

  resb_timer_s st_r;
  resb_timer_s st_nxt;

  // ----------------------------------------------------------------
  // Run counter
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt  = st_r;
    o_event = 1'b0;
    if (!i_below)
    begin
      st_nxt.cnt   = '0;
      st_nxt.fired = 1'b0;
    end
    else if (st_r.cnt == CW'(LIMIT))
    begin
      o_event      = !st_r.fired;
      st_nxt.fired = 1'b1;
    end
    else
      st_nxt.cnt = st_r.cnt + 1'b1;
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence below_gone;
    !i_below;
  endsequence

  short_fire_a: assert property (o_event |-> i_below && st_r.cnt == CW'(LIMIT) && !$past(o_event))
    else $error("short event without full run");
  run_restart_a: assert property (below_gone |=> st_r.cnt == '0 && !o_event)
    else $error("run counter not restarted");

endmodule : resb_short_timer

// ---- rtl/resb_bank.sv ----
// Event latches of two switchers and two linear regulators; live status of the two switchers and the device.
// Assumes the serial interface delivers decoded byte reads and writes in this clock domain.
//
// Summary of operation
// - Switcher b power-good event sets bit 6
// - Switcher a power-good event sets bit 2
// - Switcher b short over 1 ms sets bit 5
// - Switcher a short over 1 ms sets bit 1
// - Switcher b current limit onset sets bit 4
// - Switcher a current limit onset sets bit 0
// - Writing one clears only those event bits
// - Linear power-good events set bits 6 and 2
// - Linear short over 1 ms sets bit 5/1
// - Linear b current limit onset sets bit 4
// - Linear a current limit onset sets bit 0
// - Global bit 7 shows power-ok pin live
// - Global bit 4 shows sync clock invalid
// - Global bit 3 shows thermal shutdown live
// - Global bit 2 shows thermal warning live
// - Global bit 1 overvoltage; bits 6:5,0 zero
// - Switcher summary set while any switcher event
// - Linear summary set while any linear event
// - Switcher status bits 7,3 show enabled
// - Status bits 6,2 invalid; 4,0 limiting
`timescale 1ns/1ps
module resb_bank
  import resb_pkg::*;
#(
  parameter int SC_CYCLES = RESB_SC_CYCLES
)
(
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  // Register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // Switcher a detectors
  input  wire logic       i_switcher_a_powergood_event,
  input  wire logic       i_switcher_a_under_sc,
  input  wire logic       i_switcher_a_limiting,
  input  wire logic       i_switcher_a_enabled,
  input  wire logic       i_switcher_a_output_invalid,
  // Switcher b detectors
  input  wire logic       i_switcher_b_powergood_event,
  input  wire logic       i_switcher_b_under_sc,
  input  wire logic       i_switcher_b_limiting,
  input  wire logic       i_switcher_b_enabled,
  input  wire logic       i_switcher_b_output_invalid,
  // Linear a detectors
  input  wire logic       i_linear_a_powergood_event,
  input  wire logic       i_linear_a_under_sc,
  input  wire logic       i_linear_a_limiting,
  // Linear b detectors
  input  wire logic       i_linear_b_powergood_event,
  input  wire logic       i_linear_b_under_sc,
  input  wire logic       i_linear_b_limiting,
  // Device-wide detectors
  input  wire logic       i_power_ok_pin,
  input  wire logic       i_sync_clock_invalid,
  input  wire logic       i_thermal_shutdown_live,
  input  wire logic       i_thermal_warning_live,
  input  wire logic       i_input_overvoltage_live,
  // Summary flags
  output logic            o_switcher_summary_flag,
  output logic            o_linear_summary_flag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [RESB_NUM_REG-1:0] lim_prev;
    logic [7:0]              rdata;
  } resb_bank_s;

  resb_bank_s st_r;
  resb_bank_s st_nxt;

  logic [RESB_NUM_REG-1:0] under_sc;
  logic [RESB_NUM_REG-1:0] limiting;
  logic [RESB_NUM_REG-1:0] sc_event;
  logic [RESB_NUM_REG-1:0] lim_rise;
  logic [7:0]              gstat_word;
  logic [7:0]              swstat_word;
  logic                    wr_sw;
  logic                    wr_lin;
  logic [7:0]              sw_both;
  logic [7:0]              lin_both;

  resb_evt_if #(.W(8)) sw_evt ();
  resb_evt_if #(.W(8)) lin_evt ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] evt_word(
    input logic pg_a,
    input logic sc_a,
    input logic il_a,
    input logic pg_b,
    input logic sc_b,
    input logic il_b
  );
    logic [7:0] w;
    w                = RESB_RESET_VAL;
    w[RESB_EVT_A_PG] = pg_a;
    w[RESB_EVT_A_SC] = sc_a;
    w[RESB_EVT_A_IL] = il_a;
    w[RESB_EVT_B_PG] = pg_b;
    w[RESB_EVT_B_SC] = sc_b;
    w[RESB_EVT_B_IL] = il_b;
    return w;
  endfunction : evt_word

  // ----------------------------------------------------------------
  // Short-circuit qualification, index 0..3 = sw a, sw b, lin a, lin b
  // ----------------------------------------------------------------
  assign under_sc = {i_linear_b_under_sc, i_linear_a_under_sc,
                     i_switcher_b_under_sc, i_switcher_a_under_sc};
  assign limiting = {i_linear_b_limiting, i_linear_a_limiting,
                     i_switcher_b_limiting, i_switcher_a_limiting};

  for (genvar g = 0; g < RESB_NUM_REG; g++)
  begin : g_sc
    resb_short_timer #(
      .LIMIT   (SC_CYCLES)
    ) u_timer (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .i_below (under_sc[g]),
      .o_event (sc_event[g])
    );
  end

  // Current limit onset
  assign lim_rise = limiting & ~st_r.lim_prev;

  // ----------------------------------------------------------------
  // Event latches
  // ----------------------------------------------------------------
  assign wr_sw  = i_reg_wr && (i_reg_addr == RESB_SW_EVT_ADDR);
  assign wr_lin = i_reg_wr && (i_reg_addr == RESB_LIN_EVT_ADDR);

  assign sw_evt.set  = evt_word(i_switcher_a_powergood_event, sc_event[0], lim_rise[0],
                                i_switcher_b_powergood_event, sc_event[1], lim_rise[1]);
  assign sw_evt.clr  = wr_sw ? (i_reg_wdata & RESB_EVT_MASK) : 8'h00;
  assign lin_evt.set = evt_word(i_linear_a_powergood_event, sc_event[2], lim_rise[2],
                                i_linear_b_powergood_event, sc_event[3], lim_rise[3]);
  assign lin_evt.clr = wr_lin ? (i_reg_wdata & RESB_EVT_MASK) : 8'h00;

  assign sw_both  = sw_evt.set & sw_evt.clr;
  assign lin_both = lin_evt.set & lin_evt.clr;

  resb_event_latch #(
    .W       (8),
    .MASK    (RESB_EVT_MASK)
  ) u_sw_latch (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .evt     (sw_evt.latch)
  );

  resb_event_latch #(
    .W       (8),
    .MASK    (RESB_EVT_MASK)
  ) u_lin_latch (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .evt     (lin_evt.latch)
  );

  // Summary flags
  assign o_switcher_summary_flag = |sw_evt.q;
  assign o_linear_summary_flag   = |lin_evt.q;

  // ----------------------------------------------------------------
  // Live status words
  // ----------------------------------------------------------------
  always_comb
  begin
    gstat_word                   = RESB_RESET_VAL;
    gstat_word[RESB_GS_POWER_OK] = i_power_ok_pin;
    gstat_word[RESB_GS_SYNC_BAD] = i_sync_clock_invalid;
    gstat_word[RESB_GS_TSD]      = i_thermal_shutdown_live;
    gstat_word[RESB_GS_TWARN]    = i_thermal_warning_live;
    gstat_word[RESB_GS_OVP]      = i_input_overvoltage_live;
  end

  always_comb
  begin
    swstat_word                = RESB_RESET_VAL;
    swstat_word[RESB_SS_B_EN]  = i_switcher_b_enabled;
    swstat_word[RESB_SS_A_EN]  = i_switcher_a_enabled;
    swstat_word[RESB_SS_B_INV] = i_switcher_b_output_invalid;
    swstat_word[RESB_SS_A_INV] = i_switcher_a_output_invalid;
    swstat_word[RESB_SS_B_LIM] = i_switcher_b_limiting;
    swstat_word[RESB_SS_A_LIM] = i_switcher_a_limiting;
  end

  // ----------------------------------------------------------------
  // Read mux and edge history
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.lim_prev = limiting;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        RESB_SW_EVT_ADDR:  st_nxt.rdata = sw_evt.q;
        RESB_LIN_EVT_ADDR: st_nxt.rdata = lin_evt.q;
        RESB_GSTAT_ADDR:   st_nxt.rdata = gstat_word;
        RESB_SWSTAT_ADDR:  st_nxt.rdata = swstat_word;
        default:           st_nxt.rdata = RESB_RESET_VAL;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_reg_rdata = st_r.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence sw_clear_req;
    wr_sw && sw_evt.set == 8'h00;
  endsequence

  sequence lin_clear_req;
    wr_lin && lin_evt.set == 8'h00;
  endsequence

  sequence gstat_read;
    i_reg_rd && i_reg_addr == RESB_GSTAT_ADDR;
  endsequence

  sw_b_pg_a: assert property (i_switcher_b_powergood_event |=> sw_evt.q[RESB_EVT_B_PG])
    else $error("switcher b power-good not latched");
  sw_a_pg_a: assert property (i_switcher_a_powergood_event |=> sw_evt.q[RESB_EVT_A_PG])
    else $error("switcher a power-good not latched");
  sw_b_short_a: assert property (sc_event[1] |=> sw_evt.q[RESB_EVT_B_SC])
    else $error("switcher b short not latched");
  sw_a_short_a: assert property (sc_event[0] |=> sw_evt.q[RESB_EVT_A_SC])
    else $error("switcher a short not latched");
  sw_b_ilim_a: assert property (i_switcher_b_limiting && !$past(i_switcher_b_limiting)
                                |=> sw_evt.q[RESB_EVT_B_IL])
    else $error("switcher b limit onset not latched");
  sw_a_ilim_a: assert property (!i_switcher_a_limiting ##1 i_switcher_a_limiting
                                |=> sw_evt.q[RESB_EVT_A_IL])
    else $error("switcher a limit onset not latched");
  sw_w1c_a: assert property (sw_clear_req |=> sw_evt.q == ($past(sw_evt.q) & ~$past(i_reg_wdata)))
    else $error("switcher write-one-clear wrong");
  lin_w1c_a: assert property (lin_clear_req |=> lin_evt.q == ($past(lin_evt.q) & ~$past(i_reg_wdata)))
    else $error("linear write-one-clear wrong");
  lin_pg_a: assert property (i_linear_b_powergood_event |=> lin_evt.q[RESB_EVT_B_PG])
    else $error("linear b power-good not latched");
  lin_a_pg_a: assert property (i_linear_a_powergood_event |=> lin_evt.q[RESB_EVT_A_PG])
    else $error("linear a power-good not latched");
  lin_short_a: assert property (sc_event[3] |=> lin_evt.q[RESB_EVT_B_SC])
    else $error("linear b short not latched");
  lin_b_ilim_a: assert property (lim_rise[3] |=> lin_evt.q[RESB_EVT_B_IL])
    else $error("linear b limit onset not latched");
  lin_a_ilim_a: assert property (i_linear_a_limiting && !$past(i_linear_a_limiting)
                                 |=> lin_evt.q[RESB_EVT_A_IL])
    else $error("linear a limit onset not latched");
  gstat_read_a: assert property (gstat_read |=> o_reg_rdata == {$past(i_power_ok_pin), 2'b00,
                                 $past(i_sync_clock_invalid), $past(i_thermal_shutdown_live),
                                 $past(i_thermal_warning_live), $past(i_input_overvoltage_live), 1'b0})
    else $error("global status read wrong");
  sw_summary_a: assert property (wr_sw && sw_evt.set == 8'h00 && (sw_evt.q & ~i_reg_wdata) == 8'h00
                                 |=> !o_switcher_summary_flag)
    else $error("switcher summary not cleared");
  lin_summary_a: assert property (i_linear_b_powergood_event |=> o_linear_summary_flag)
    else $error("linear summary not raised");
  swstat_read_a: assert property (i_reg_rd && i_reg_addr == RESB_SWSTAT_ADDR
                                  |=> o_reg_rdata[RESB_SS_B_EN] == $past(i_switcher_b_enabled)
                                  && o_reg_rdata[RESB_SS_A_LIM] == $past(i_switcher_a_limiting)
                                  && o_reg_rdata[5] == 1'b0)
    else $error("switcher status read wrong");
  set_wins_a: assert property ((|sw_both) |=> (sw_evt.q & $past(sw_both)) == $past(sw_both))
    else $error("event lost against clear");
  lin_set_wins_a: assert property ((|lin_both) |=> (lin_evt.q & $past(lin_both)) == $past(lin_both))
    else $error("linear event lost against clear");
  status_ro_a: assert property (i_reg_wr && i_reg_addr == RESB_GSTAT_ADDR && sw_evt.set == 8'h00
                                |=> sw_evt.q == $past(sw_evt.q))
    else $error("status write disturbed latches");

  // ----------------------------------------------------------------
  // Summary, read-back, status write and linear a short checks
  // ----------------------------------------------------------------
  swstat_ro_a: assert property (i_reg_wr && i_reg_addr == RESB_SWSTAT_ADDR && sw_evt.set == 8'h00
                                |=> sw_evt.q == $past(sw_evt.q))
    else $error("switcher status write disturbed latches");
  lin_summary_clr_a: assert property (wr_lin && lin_evt.set == 8'h00 && (lin_evt.q & ~i_reg_wdata) == 8'h00
                                      |=> !o_linear_summary_flag)
    else $error("linear summary not cleared");
  sw_summary_set_a: assert property ((|sw_evt.set) |=> o_switcher_summary_flag)
    else $error("switcher summary not raised");
  lin_summary_set_a: assert property ((|lin_evt.set) |=> o_linear_summary_flag)
    else $error("linear summary not raised on event");
  lin_a_short_a: assert property (sc_event[2] |=> lin_evt.q[RESB_EVT_A_SC])
    else $error("linear a short not latched");
  sw_read_a: assert property (i_reg_rd && i_reg_addr == RESB_SW_EVT_ADDR
                              |=> o_reg_rdata == $past(sw_evt.q))
    else $error("switcher event read wrong");
  lin_read_a: assert property (i_reg_rd && i_reg_addr == RESB_LIN_EVT_ADDR
                               |=> o_reg_rdata == $past(lin_evt.q))
    else $error("linear event read wrong");

endmodule : resb_bank

// ---- tb/resb_host_model.sv ----
// Host side of the bank's byte register port.
// Assumes strobes are taken on the rising edge of i_clock.
`timescale 1ns/1ps
module resb_host_model
(
  // Clock
  input  wire logic       i_clock,
  // Register port
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata,
  input  wire logic [7:0] i_rdata
);
  initial
  begin
    o_addr  = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end

  // Released lines show the inverse of their last value
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clock);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clock);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clock);
    d = i_rdata;
  endtask : reg_read
endmodule : resb_host_model

// ---- tb/testbench.sv ----
// Self-checking bench for the regulator event and status bank.
// Assumes the host model drives the register port; bench drives detectors.
`timescale 1ns/1ps
module testbench;
  import resb_pkg::*;
  localparam int SC = 8;
  localparam int POS [11] = '{7, 4, 3, 2, 1, 3, 7, 2, 6, 0, 4};
  logic        i_clock;
  logic        i_nrst;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        wr;
  logic        rd;
  logic [11:0] evt;
  logic [10:0] st;
  logic        sw_flag;
  logic        ln_flag;
  logic [7:0]  ra;
  int          b;
  int          err_total;
  int          checks;

  always #2.5 i_clock = ~i_clock;

  resb_host_model host (.i_clock(i_clock), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
                        .i_rdata(rdata));

  resb_bank #(.SC_CYCLES(SC)) dut (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_switcher_a_powergood_event(evt[0]), .i_switcher_b_powergood_event(evt[1]),
    .i_switcher_a_under_sc(evt[2]), .i_switcher_b_under_sc(evt[3]),
    .i_switcher_a_limiting(evt[4] | st[9]), .i_switcher_b_limiting(evt[5] | st[10]),
    .i_switcher_a_enabled(st[5]), .i_switcher_b_enabled(st[6]),
    .i_switcher_a_output_invalid(st[7]), .i_switcher_b_output_invalid(st[8]),
    .i_linear_a_powergood_event(evt[6]), .i_linear_b_powergood_event(evt[7]),
    .i_linear_a_under_sc(evt[8]), .i_linear_b_under_sc(evt[9]),
    .i_linear_a_limiting(evt[10]), .i_linear_b_limiting(evt[11]),
    .i_power_ok_pin(st[0]), .i_sync_clock_invalid(st[1]), .i_thermal_shutdown_live(st[2]),
    .i_thermal_warning_live(st[3]), .i_input_overvoltage_live(st[4]),
    .o_switcher_summary_flag(sw_flag), .o_linear_summary_flag(ln_flag));

  // ----------------------------------------------------------------
  // Compare and access tasks
  // ----------------------------------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t byte read %h expected %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.reg_read(a, v);
    check_byte(v, e);
  endtask : rd_chk

  // Drive one detector for len edges
  task automatic fire(input int idx, input int len);
    @(posedge i_clock);
    evt[idx] <= 1'b1;
    repeat (len) @(posedge i_clock);
    evt <= '0;
    repeat (2) @(posedge i_clock);
  endtask : fire

  task finish_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  initial
  begin
    #200000;
    err_total++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    i_clock   = 1'b0;
    i_nrst    = 1'b0;
    evt       = '0;
    st        = '0;
    err_total = 0;
    checks    = 0;
    repeat (10) @(posedge i_clock);
    i_nrst <= 1'b1;
    for (int i = 0; i < 5; i++) rd_chk(8'h1b + i[7:0], 8'h00);
    $display("test reset done");

    for (int lin = 0; lin < 2; lin++)
      for (int k = 0; k < 3; k++)
        for (int s = 0; s < 2; s++)
        begin
          ra = lin ? RESB_LIN_EVT_ADDR : RESB_SW_EVT_ADDR;
          b  = s * 4 + 2 - k;
          if (k == 1)
          begin
            fire(lin * 6 + k * 2 + s, SC);
            rd_chk(ra, 8'h00);
          end
          fire(lin * 6 + k * 2 + s, (k == 1) ? SC + 1 : 3);
          rd_chk(ra, 8'h01 << b);
          check_bit(lin ? ln_flag : sw_flag, 1'b1);
          host.reg_write(ra, 8'h01 << b);
          rd_chk(ra, 8'h00);
          check_bit(lin ? ln_flag : sw_flag, 1'b0);
        end
    $display("test events done");

    fire(0, 1);
    fire(1, 1);
    fire(4, 2);
    rd_chk(RESB_SW_EVT_ADDR, 8'h45);
    host.reg_write(RESB_SW_EVT_ADDR, 8'h04);
    rd_chk(RESB_SW_EVT_ADDR, 8'h41);
    host.reg_write(RESB_SW_EVT_ADDR, 8'h88);
    rd_chk(RESB_SW_EVT_ADDR, 8'h41);
    host.reg_write(RESB_SW_EVT_ADDR, 8'h41);
    rd_chk(RESB_SW_EVT_ADDR, 8'h00);
    fork
      host.reg_write(RESB_SW_EVT_ADDR, 8'h40);
      begin
        @(posedge i_clock);
        evt[1] <= 1'b1;
        @(posedge i_clock);
        evt[1] <= 1'b0;
      end
    join
    rd_chk(RESB_SW_EVT_ADDR, 8'h40);
    check_bit(sw_flag, 1'b1);
    host.reg_write(RESB_SW_EVT_ADDR, 8'h40);
    $display("test clear done");

    for (int j = 0; j < 11; j++)
    begin
      st <= 11'h001 << j;
      rd_chk((j < 5) ? RESB_GSTAT_ADDR : RESB_SWSTAT_ADDR, 8'h01 << POS[j]);
    end
    st <= '1;
    host.reg_write(RESB_GSTAT_ADDR, 8'h00);
    host.reg_write(RESB_SWSTAT_ADDR, 8'h00);
    rd_chk(RESB_GSTAT_ADDR, 8'h9e);
    rd_chk(RESB_SWSTAT_ADDR, 8'hdd);
    st <= '0;
    rd_chk(RESB_SWSTAT_ADDR, 8'h00);
    rd_chk(RESB_SW_EVT_ADDR, 8'h11);
    host.reg_write(RESB_SW_EVT_ADDR, 8'h77);
    rd_chk(RESB_SW_EVT_ADDR, 8'h00);
    check_bit(sw_flag, 1'b0);
    $display("test status done");

    fire(7, 1);
    check_bit(ln_flag, 1'b1);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    check_bit(ln_flag, 1'b0);
    rd_chk(RESB_LIN_EVT_ADDR, 8'h00);
    rd_chk(RESB_SW_EVT_ADDR, 8'h00);
    $display("test reset again done");
    finish_test();
  end
endmodule : testbench
